// *** hdl/quad_timer_counter_block.sv ***
// Quad 16-bit timer/counter: two timer pairs, register port and interrupt status
//
// Chosen here: strobed register access.
`timescale 1ns/1ps

module timer_pair
  import quad_timer_pkg::*;
#(
  parameter bit HAS_EXT_INT = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wr_ctrl,
  input wire logic wr_mode,
  input wire logic [3:0] wr_cnt,
  input wire logic [7:0] wdata,
  input wire logic [1:0] count_pin,
  input wire logic [1:0] external_gate_pin,
  input wire logic sub_rise,
  input wire logic [1:0] ack_ovf,
  input wire logic [1:0] ack_ext,
  output logic [7:0] ctrl_q,
  output logic [7:0] mode_q,
  output logic [7:0] tl_a_reg,
  output logic [7:0] th_a_reg,
  output logic [7:0] tl_b_reg,
  output logic [7:0] th_b_reg,
  output logic [1:0] ovf_evt_reg,
  output logic [1:0] ext_evt_reg
);

  logic run_a_reg;
  logic run_b_reg;
  logic flag_a_reg;
  logic flag_b_reg;
  logic slow_a_reg;
  logic slow_b_reg;
  logic [1:0] ext_flag_reg;
  logic [1:0] ext_type_reg;
  logic [7:0] mode_reg;
  logic [1:0] pin_prev_reg;
  logic [1:0] gate_prev_reg;
  timer_mode_t mode_a;
  timer_mode_t mode_b;
  logic tick_a;
  logic tick_b;
  logic tick_split;
  logic [1:0] src;
  logic [1:0] ext_set;
  logic ovf_a;
  logic ovf_b;
  count_state_t next_a;
  count_state_t next_b;
  count_state_t next_split;

  // One counting step in the selected mode
  function automatic count_state_t count_step(input timer_mode_t mode, input logic [7:0] tl,
                                              input logic [7:0] th);
    count_state_t r;
    r.tl = tl;
    r.th = th;
    r.ovf = 1'b0;
    case (mode)
      MODE_13BIT: begin
        // Upper three bits of the low byte are left alone in this mode
        r.tl[4:0] = tl[4:0] + 5'h01;
        if (tl[4:0] == PRESC_MAX) begin
          r.th = th + 8'h01;
          r.ovf = (th == BYTE_MAX);
        end
      end
      MODE_16BIT: begin
        r.tl = tl + 8'h01;
        if (tl == BYTE_MAX) begin
          r.th = th + 8'h01;
          r.ovf = (th == BYTE_MAX);
        end
      end
      MODE_RELOAD8: begin
        r.tl = (tl == BYTE_MAX) ? th : tl + 8'h01;
        r.ovf = (tl == BYTE_MAX);
      end
      MODE_SPLIT: begin
        r.tl = tl + 8'h01;
        r.ovf = (tl == BYTE_MAX);
      end
      default: begin
        r.ovf = 1'b0;
      end
    endcase
    return r;
  endfunction

  assign mode_a = timer_mode_t'(mode_reg[B_MODE_HIGH:B_MODE_LOW]);
  assign mode_b = timer_mode_t'(mode_reg[NIB_HI+B_MODE_HIGH:NIB_HI+B_MODE_LOW]);

  // Count source: pin falling edge, else main clock or slow oscillator edge
  always_comb begin
    src[0] = mode_reg[B_CNT_SEL] ? (pin_prev_reg[0] & ~count_pin[0])
                                 : (slow_a_reg ? sub_rise : 1'b1);
    src[1] = mode_reg[NIB_HI+B_CNT_SEL] ? (pin_prev_reg[1] & ~count_pin[1])
                                        : (slow_b_reg ? sub_rise : 1'b1);
  end

  // Run and gate qualification
  assign tick_a = run_a_reg & (~mode_reg[B_GATE] | external_gate_pin[0]) & src[0];
  assign tick_b = run_b_reg & (~mode_reg[NIB_HI+B_GATE] | external_gate_pin[1]) & src[1]
                  & (mode_b != MODE_SPLIT);
  // Split high byte is a plain timer on the second timer's run bit
  assign tick_split = (mode_a == MODE_SPLIT) & run_b_reg & (slow_a_reg ? sub_rise : 1'b1);

  assign next_a = count_step(mode_a, tl_a_reg, th_a_reg);
  assign next_b = count_step(mode_b, tl_b_reg, th_b_reg);
  assign next_split = count_step(MODE_SPLIT, th_a_reg, RESET_BYTE);

  // While the first timer is split, its high byte owns the second flag
  assign ovf_a = tick_a & next_a.ovf;
  assign ovf_b = (mode_a == MODE_SPLIT) ? (tick_split & next_split.ovf) : (tick_b & next_b.ovf);

  // External interrupt detect: falling edge when type set, low level otherwise
  always_comb begin
    ext_set[0] = HAS_EXT_INT & (ext_type_reg[0] ? (gate_prev_reg[0] & ~external_gate_pin[0])
                                               : ~external_gate_pin[0]);
    ext_set[1] = HAS_EXT_INT & (ext_type_reg[1] ? (gate_prev_reg[1] & ~external_gate_pin[1])
                                               : ~external_gate_pin[1]);
  end

  // Edge detector history
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_prev_reg <= 2'h0;
      gate_prev_reg <= 2'h0;
    end else begin
      pin_prev_reg <= count_pin;
      gate_prev_reg <= external_gate_pin;
    end
  end

  // Mode register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= RESET_BYTE;
    end else if (wr_mode) begin
      mode_reg <= wdata;
    end
  end

  // Software run, type and slow-oscillator bits
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      run_a_reg <= 1'b0;
      run_b_reg <= 1'b0;
      ext_type_reg <= 2'h0;
      slow_a_reg <= 1'b0;
      slow_b_reg <= 1'b0;
    end else if (wr_ctrl) begin
      run_a_reg <= wdata[B_RUN_LO];
      run_b_reg <= wdata[B_RUN_HI];
      if (HAS_EXT_INT) begin
        ext_type_reg <= {wdata[B_EXT1_TYPE], wdata[B_EXT0_TYPE]};
      end else begin
        slow_a_reg <= wdata[B_SLOW_LO];
        slow_b_reg <= wdata[B_SLOW_HI];
      end
    end
  end

  // Overflow flags: hardware set beats acknowledge, which beats software write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end else begin
      if (ovf_a) begin
        flag_a_reg <= 1'b1;
      end else if (ack_ovf[0]) begin
        flag_a_reg <= 1'b0;
      end else if (wr_ctrl) begin
        flag_a_reg <= wdata[B_FLAG_LO];
      end
      if (ovf_b) begin
        flag_b_reg <= 1'b1;
      end else if (ack_ovf[1]) begin
        flag_b_reg <= 1'b0;
      end else if (wr_ctrl) begin
        flag_b_reg <= wdata[B_FLAG_HI];
      end
    end
  end

  // External interrupt flags, set winning over processing clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ext_flag_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ext_set[i]) begin
          ext_flag_reg[i] <= 1'b1;
        end else if (ack_ext[i]) begin
          ext_flag_reg[i] <= 1'b0;
        end else if (wr_ctrl && HAS_EXT_INT) begin
          ext_flag_reg[i] <= (i == 0) ? wdata[B_EXT0_FLAG] : wdata[B_EXT1_FLAG];
        end
      end
    end
  end

  // First timer count registers; a software write takes precedence over a step
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tl_a_reg <= RESET_BYTE;
      th_a_reg <= RESET_BYTE;
    end else begin
      if (wr_cnt[0]) begin
        tl_a_reg <= wdata;
      end else if (tick_a) begin
        tl_a_reg <= next_a.tl;
      end
      if (wr_cnt[2]) begin
        th_a_reg <= wdata;
      end else if (mode_a == MODE_SPLIT) begin
        if (tick_split) begin
          th_a_reg <= next_split.tl;
        end
      end else if (tick_a) begin
        th_a_reg <= next_a.th;
      end
    end
  end

  // Second timer count registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tl_b_reg <= RESET_BYTE;
      th_b_reg <= RESET_BYTE;
    end else begin
      if (wr_cnt[1]) begin
        tl_b_reg <= wdata;
      end else if (tick_b) begin
        tl_b_reg <= next_b.tl;
      end
      if (wr_cnt[3]) begin
        th_b_reg <= wdata;
      end else if (tick_b) begin
        th_b_reg <= next_b.th;
      end
    end
  end

  // Event pulses toward the interrupt status register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ovf_evt_reg <= 2'h0;
      ext_evt_reg <= 2'h0;
    end else begin
      ovf_evt_reg <= {ovf_b, ovf_a};
      ext_evt_reg <= ext_set & ~ext_flag_reg;
    end
  end

  // Readback: slow-oscillator bits are write-only, reserved bits read zero
  always_comb begin
    ctrl_q = RESET_BYTE;
    ctrl_q[B_FLAG_HI] = flag_b_reg;
    ctrl_q[B_RUN_HI] = run_b_reg;
    ctrl_q[B_FLAG_LO] = flag_a_reg;
    ctrl_q[B_RUN_LO] = run_a_reg;
    if (HAS_EXT_INT) begin
      ctrl_q[B_EXT1_FLAG] = ext_flag_reg[1];
      ctrl_q[B_EXT1_TYPE] = ext_type_reg[1];
      ctrl_q[B_EXT0_FLAG] = ext_flag_reg[0];
      ctrl_q[B_EXT0_TYPE] = ext_type_reg[0];
    end
    mode_q = mode_reg;
  end

endmodule

module quad_timer_counter_block
  import quad_timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] count_pin,
  input wire logic [3:0] external_gate_pin,
  input wire logic sub_osc_clk,
  input wire logic [5:0] vector_ack,
  output logic irq
);

  bus_req_t req;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic [IRQ_BITS-1:0] status_reg;
  logic [IRQ_BITS-1:0] mask_reg;
  logic [IRQ_BITS-1:0] evt;
  logic sub_prev_reg;
  logic sub_rise;
  logic status_clr;
  logic [7:0] rdata_next;
  logic [7:0] ctrl01;
  logic [7:0] mode01;
  logic [7:0] ctrl34;
  logic [7:0] mode34;
  logic [7:0] tl0, th0, tl1, th1, tl3, th3, tl4, th4;
  logic [1:0] ovf01, ext01, ovf34, ext34;
  logic [3:0] wr_cnt01;
  logic [3:0] wr_cnt34;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign sub_rise = ~sub_prev_reg & sub_osc_clk;
  assign status_clr = req.rd && req.addr == ADDR_IRQ_STATUS;

  // Count register write decode: low bytes then high bytes
  assign wr_cnt01 = {req.wr & (req.addr == ADDR_TH1), req.wr & (req.addr == ADDR_TH0),
                     req.wr & (req.addr == ADDR_TL1), req.wr & (req.addr == ADDR_TL0)};
  assign wr_cnt34 = {req.wr & (req.addr == ADDR_TH4), req.wr & (req.addr == ADDR_TH3),
                     req.wr & (req.addr == ADDR_TL4), req.wr & (req.addr == ADDR_TL3)};

  // Slow oscillator edge history
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sub_prev_reg <= 1'b0;
    end else begin
      sub_prev_reg <= sub_osc_clk;
    end
  end

  timer_pair #(.HAS_EXT_INT(1'b1)) pair01 (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_ctrl(req.wr & (req.addr == ADDR_CTRL01)),
    .wr_mode(req.wr & (req.addr == ADDR_MODE01)),
    .wr_cnt(wr_cnt01),
    .wdata(req.wdata),
    .count_pin(count_pin[1:0]),
    .external_gate_pin(external_gate_pin[1:0]),
    .sub_rise(1'b0),
    .ack_ovf({vector_ack[IRQ_TIMER1], vector_ack[IRQ_TIMER0]}),
    .ack_ext({vector_ack[IRQ_EXT1], vector_ack[IRQ_EXT0]}),
    .ctrl_q(ctrl01),
    .mode_q(mode01),
    .tl_a_reg(tl0),
    .th_a_reg(th0),
    .tl_b_reg(tl1),
    .th_b_reg(th1),
    .ovf_evt_reg(ovf01),
    .ext_evt_reg(ext01)
  );

  timer_pair #(.HAS_EXT_INT(1'b0)) pair34 (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_ctrl(req.wr & (req.addr == ADDR_CTRL34)),
    .wr_mode(req.wr & (req.addr == ADDR_MODE34)),
    .wr_cnt(wr_cnt34),
    .wdata(req.wdata),
    .count_pin(count_pin[3:2]),
    .external_gate_pin(external_gate_pin[3:2]),
    .sub_rise(sub_rise),
    .ack_ovf({vector_ack[IRQ_TIMER4], vector_ack[IRQ_TIMER3]}),
    .ack_ext(2'h0),
    .ctrl_q(ctrl34),
    .mode_q(mode34),
    .tl_a_reg(tl3),
    .th_a_reg(th3),
    .tl_b_reg(tl4),
    .th_b_reg(th4),
    .ovf_evt_reg(ovf34),
    .ext_evt_reg()
  );

  assign ext34 = 2'h0;
  assign evt = {ext01 | ext34, ovf34, ovf01};

  // Sticky status; a read clears it but a same-cycle event still lands
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_reg <= '0;
    end else if (status_clr) begin
      status_reg <= evt;
    end else begin
      status_reg <= status_reg | evt;
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mask_reg <= '0;
    end else if (req.wr && req.addr == ADDR_IRQ_MASK) begin
      mask_reg <= req.wdata[IRQ_BITS-1:0];
    end
  end

  // Level interrupt from a flop; tracks the status value so a read clear drops it too
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |((status_clr ? evt : (status_reg | evt)) & mask_reg);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = RESET_BYTE;
    case (req.addr)
      ADDR_CTRL01: rdata_next = ctrl01;
      ADDR_MODE01: rdata_next = mode01;
      ADDR_TL0: rdata_next = tl0;
      ADDR_TL1: rdata_next = tl1;
      ADDR_TH0: rdata_next = th0;
      ADDR_TH1: rdata_next = th1;
      ADDR_CTRL34: rdata_next = ctrl34;
      ADDR_MODE34: rdata_next = mode34;
      ADDR_TL3: rdata_next = tl3;
      ADDR_TL4: rdata_next = tl4;
      ADDR_TH3: rdata_next = th3;
      ADDR_TH4: rdata_next = th4;
      ADDR_IRQ_STATUS: rdata_next = {2'h0, status_reg};
      ADDR_IRQ_MASK: rdata_next = {2'h0, mask_reg};
      default: rdata_next = RESET_BYTE;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= RESET_BYTE;
    end else begin
      rdata_reg <= req.rd ? rdata_next : RESET_BYTE;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;

endmodule

// *** hdl/quad_timer_pkg.sv ***
// Shared constants and types for the quad timer/counter block
package quad_timer_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_CTRL01 = 8'h88;
  localparam logic [7:0] ADDR_MODE01 = 8'h89;
  localparam logic [7:0] ADDR_TL0 = 8'h8A;
  localparam logic [7:0] ADDR_TL1 = 8'h8B;
  localparam logic [7:0] ADDR_TH0 = 8'h8C;
  localparam logic [7:0] ADDR_TH1 = 8'h8D;
  localparam logic [7:0] ADDR_CTRL34 = 8'h90;
  localparam logic [7:0] ADDR_MODE34 = 8'h91;
  localparam logic [7:0] ADDR_TL3 = 8'h92;
  localparam logic [7:0] ADDR_TL4 = 8'h93;
  localparam logic [7:0] ADDR_TH3 = 8'h94;
  localparam logic [7:0] ADDR_TH4 = 8'h95;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h98;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h99;

  // Control register field positions (run and flag bits same for both pairs)
  localparam int B_FLAG_HI = 7;
  localparam int B_RUN_HI = 6;
  localparam int B_FLAG_LO = 5;
  localparam int B_RUN_LO = 4;
  localparam int B_EXT1_FLAG = 3;
  localparam int B_EXT1_TYPE = 2;
  localparam int B_EXT0_FLAG = 1;
  localparam int B_EXT0_TYPE = 0;
  localparam int B_SLOW_LO = 2;
  localparam int B_SLOW_HI = 0;

  // Mode nibble field positions (low nibble: first timer, high nibble: second)
  localparam int B_GATE = 3;
  localparam int B_CNT_SEL = 2;
  localparam int B_MODE_HIGH = 1;
  localparam int B_MODE_LOW = 0;
  localparam int NIB_HI = 4;

  // Byte counter and 13-bit prescaler limits
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [4:0] PRESC_MAX = 5'h1F;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Interrupt status / mask bit positions
  localparam int IRQ_TIMER0 = 0;
  localparam int IRQ_TIMER1 = 1;
  localparam int IRQ_TIMER3 = 2;
  localparam int IRQ_TIMER4 = 3;
  localparam int IRQ_EXT0 = 4;
  localparam int IRQ_EXT1 = 5;
  localparam int IRQ_BITS = 6;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_t;

  // One register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // Count pair state and overflow result of one step
  typedef struct packed {
    logic [7:0] tl;
    logic [7:0] th;
    logic ovf;
  } count_state_t;

endpackage

// *** testbench/pin_model.sv ***
// Far-side model of the count, gate and slow oscillator pins
`timescale 1ns/1ps
module pin_model (
  input wire logic ref_clk,
  output logic [3:0] count_pin,
  output logic [3:0] external_gate_pin,
  output logic sub_osc_clk
);
  // Pins idle high; the slow oscillator stands low until asked to run
  initial begin
    count_pin = 4'hF;
    external_gate_pin = 4'hF;
    sub_osc_clk = 1'b0;
  end

  // Falling edges on one count pin, each low held a full cycle
  task automatic fall(input int i, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk) count_pin[i] <= 1'b0;
      @(posedge ref_clk) count_pin[i] <= 1'b1;
    end
  endtask

  task automatic gate(input int i, input logic v);
    @(posedge ref_clk) external_gate_pin[i] <= v;
  endtask

  // Slow rises, far slower than the system clock
  task automatic slow(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk) sub_osc_clk <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sub_osc_clk <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule

// *** testbench/quad_timer_counter_block_properties.sv ***
// Port checker for the quad timer/counter block, bound to its top module
`timescale 1ns/1ps
module quad_timer_checker
  import quad_timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] count_pin,
  input wire logic [3:0] external_gate_pin,
  input wire logic sub_osc_clk,
  input wire logic [5:0] vector_ack,
  input wire logic irq
);
  logic [7:0] c01_reg, m01_reg, c34_reg, m34_reg;
  logic mask_seen_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Shadows of software control bits; hardware never changes run or mode bits
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      c01_reg <= 8'h00;
      m01_reg <= 8'h00;
      c34_reg <= 8'h00;
      m34_reg <= 8'h00;
      mask_seen_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CTRL01) c01_reg <= reg_wdata;
      if (reg_addr == ADDR_MODE01) m01_reg <= reg_wdata;
      if (reg_addr == ADDR_CTRL34) c34_reg <= reg_wdata;
      if (reg_addr == ADDR_MODE34) m34_reg <= reg_wdata;
      if (reg_addr == ADDR_IRQ_MASK && reg_wdata != 8'h00) mask_seen_reg <= 1'b1;
    end
  end

  // Conditions under which a counter must stand still, or tick every cycle
  wire logic t0_hold = !c01_reg[B_RUN_LO] || (m01_reg[B_GATE] && !external_gate_pin[0]);
  wire logic t0_tick = c01_reg[B_RUN_LO] && m01_reg[3:0] == 4'h1;
  wire logic t1_hold = m01_reg[5:4] == 2'b11;
  wire logic t3_hold = !c34_reg[B_RUN_LO];

  // Write, one idle cycle with the condition, then read of the same place
  sequence s_gap(logic [7:0] a, logic h);
    (h && reg_wr && reg_addr == a) ##1 (h && !(reg_wr && reg_addr == a)) ##1 (reg_rd && reg_addr == a);
  endsequence

  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside answer cycle");

  property p_ctrl34_wo;
    $past(reg_rd) && $past(reg_addr) == ADDR_CTRL34 |-> reg_rdata[3:0] == 4'h0;
  endproperty
  a_ctrl34_wo: assert property (p_ctrl34_wo) else $error("write-only or reserved bits read back");

  property p_mode01_rw;
    s_gap(ADDR_MODE01, 1'b1) |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_mode01_rw: assert property (p_mode01_rw) else $error("mode register read differs from write");

  property p_irq_nomask;
    !mask_seen_reg |-> !irq;
  endproperty
  a_irq_nomask: assert property (p_irq_nomask) else $error("irq high with nothing unmasked");

  property p_t0_stop;
    s_gap(ADDR_TL0, t0_hold) |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_t0_stop: assert property (p_t0_stop) else $error("timer 0 moved while stopped or gated");

  property p_t0_count;
    s_gap(ADDR_TL0, t0_tick) |=> reg_rdata == $past(reg_wdata, 3) + 8'h01;
  endproperty
  a_t0_count: assert property (p_t0_count) else $error("timer 0 did not tick on system clock");

  property p_t1_stop;
    s_gap(ADDR_TL1, t1_hold) |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_t1_stop: assert property (p_t1_stop) else $error("timer 1 moved in mode 3");

  property p_t3_stop;
    s_gap(ADDR_TL3, t3_hold) |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_t3_stop: assert property (p_t3_stop) else $error("timer 3 moved with run bit clear");
endmodule

bind quad_timer_counter_block quad_timer_checker quad_timer_checker_i (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .count_pin(count_pin), .external_gate_pin(external_gate_pin), .sub_osc_clk(sub_osc_clk),
  .vector_ack(vector_ack), .irq(irq));

// *** testbench/quad_timer_counter_block_tb.sv ***
// Self-checking bench for the quad timer/counter block
`timescale 1ns/1ps
module quad_timer_counter_block_tb
  import quad_timer_pkg::*;
;
  logic ref_clk, reset, reg_wr, reg_rd, irq, sub_osc_clk;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] count_pin, external_gate_pin;
  logic [5:0] vector_ack;
  int err_count, n_checks;

  quad_timer_counter_block quad_timer_counter_block_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_pin(count_pin),
    .external_gate_pin(external_gate_pin), .sub_osc_clk(sub_osc_clk), .vector_ack(vector_ack), .irq(irq));
  pin_model pin_model_i (.ref_clk(ref_clk), .count_pin(count_pin), .external_gate_pin(external_gate_pin),
    .sub_osc_clk(sub_osc_clk));

  // 200 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Bus cycles leave one idle cycle, so strobes never need a double assignment
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Read answer stands only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic ack(input int i);
    @(posedge ref_clk) vector_ack[i] <= 1'b1;
    @(posedge ref_clk) vector_ack <= 6'h00;
  endtask

  task automatic ci(input logic e);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, irq}, {7'h00, e});
  endtask

  task automatic t_regs;
    logic [7:0] al [6] = '{ADDR_CTRL01, ADDR_MODE01, ADDR_CTRL34, ADDR_MODE34, ADDR_IRQ_MASK, 8'h80};
    foreach (al[k]) rc(al[k], 8'h00);
    wr(8'h80, 8'h5A);
    rc(8'h80, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_pair01;
    wr(ADDR_CTRL01, 8'h10);
    wr(ADDR_MODE01, 8'h01);
    rc(ADDR_MODE01, 8'h01);
    wr(ADDR_TL0, 8'h10);
    rc(ADDR_TL0, 8'h11);
    wr(ADDR_CTRL01, 8'h00);
    wr(ADDR_TL0, 8'h55);
    rc(ADDR_TL0, 8'h55);
    wr(ADDR_MODE01, 8'h05);
    wr(ADDR_CTRL01, 8'h10);
    wr(ADDR_TL0, 8'h10);
    pin_model_i.fall(0, 3);
    rc(ADDR_TL0, 8'h13);
    // Thirteen-bit: the prescaler rollover carries into the high byte
    wr(ADDR_CTRL01, 8'h00);
    wr(ADDR_MODE01, 8'h00);
    wr(ADDR_TH0, 8'h05);
    wr(ADDR_TL0, 8'hFF);
    wr(ADDR_CTRL01, 8'h10);
    rc(ADDR_TH0, 8'h06);
    rc(ADDR_TL0, 8'hE2);
    // Auto-reload overflow, flag, acknowledge and sticky status
    wr(ADDR_CTRL01, 8'h00);
    wr(ADDR_MODE01, 8'h02);
    wr(ADDR_TH0, 8'h80);
    wr(ADDR_TL0, 8'hFF);
    wr(ADDR_CTRL01, 8'h10);
    rc(ADDR_CTRL01, 8'h30);
    rc(ADDR_TL0, 8'h82);
    ack(0);
    rc(ADDR_CTRL01, 8'h10);
    rc(ADDR_IRQ_STATUS, 8'h01);
    rc(ADDR_IRQ_STATUS, 8'h00);
    // Split mode: high byte of timer 0 runs under the timer 1 run bit
    wr(ADDR_CTRL01, 8'h00);
    wr(ADDR_MODE01, 8'h03);
    wr(ADDR_TL0, 8'h33);
    wr(ADDR_TH0, 8'h10);
    wr(ADDR_CTRL01, 8'h40);
    rc(ADDR_TH0, 8'h11);
    rc(ADDR_TL0, 8'h33);
    wr(ADDR_MODE01, 8'h30);
    wr(ADDR_TL1, 8'h44);
    rc(ADDR_TL1, 8'h44);
    $display("t_pair01 done");
  endtask

  task automatic t_pair34;
    wr(ADDR_CTRL34, 8'h00);
    wr(ADDR_TL3, 8'h55);
    rc(ADDR_TL3, 8'h55);
    wr(ADDR_MODE34, 8'h09);
    wr(ADDR_CTRL34, 8'h10);
    pin_model_i.gate(2, 1'b0);
    wr(ADDR_TL3, 8'h20);
    rc(ADDR_TL3, 8'h20);
    pin_model_i.gate(2, 1'b1);
    wr(ADDR_TL3, 8'h20);
    rc(ADDR_TL3, 8'h21);
    // Slow oscillator as count source; select bits read back as zero
    wr(ADDR_MODE34, 8'h01);
    wr(ADDR_CTRL34, 8'h14);
    rc(ADDR_CTRL34, 8'h10);
    wr(ADDR_TL3, 8'h30);
    pin_model_i.slow(2);
    rc(ADDR_TL3, 8'h32);
    wr(ADDR_MODE34, 8'h10);
    wr(ADDR_CTRL34, 8'h41);
    wr(ADDR_TL4, 8'h40);
    pin_model_i.slow(1);
    rc(ADDR_TL4, 8'h41);
    wr(ADDR_MODE34, 8'h33);
    wr(ADDR_CTRL34, 8'h40);
    wr(ADDR_TL4, 8'h44);
    wr(ADDR_TH3, 8'h10);
    rc(ADDR_TH3, 8'h11);
    rc(ADDR_TL4, 8'h44);
    wr(ADDR_CTRL34, 8'h00);
    $display("t_pair34 done");
  endtask

  task automatic t_ext;
    wr(ADDR_CTRL01, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h10);
    pin_model_i.gate(0, 1'b0);
    rc(ADDR_CTRL01, 8'h03);
    ci(1'b1);
    ack(4);
    rc(ADDR_CTRL01, 8'h01);
    // Low level re-triggers while the pin stays low
    wr(ADDR_CTRL01, 8'h00);
    rc(ADDR_CTRL01, 8'h02);
    wr(ADDR_IRQ_MASK, 8'h00);
    ci(1'b0);
    pin_model_i.gate(0, 1'b1);
    ack(4);
    rc(ADDR_CTRL01, 8'h00);
    rc(ADDR_IRQ_STATUS, 8'h10);
    rc(ADDR_IRQ_STATUS, 8'h00);
    $display("t_ext done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run is a few hundred cycles; the watchdog allows far more
  initial begin
    #20000;
    err_count++;
    end_sim();
  end

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    vector_ack = 6'h00;
    err_count = 0;
    n_checks = 0;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_pair01();
    t_pair34();
    t_ext();
    end_sim();
  end
endmodule
